// [core/acmp_ctrl.sv]
// Digital control, status and edge-interrupt logic for four analog comparators
//
// Overview of operation
// - Four channels, each active only when enabled
// - Two 8-bit threshold codes, 256 steps
// - Channel A choice selects first or second
// - Channels B-D choose first or external
// - Invert bit flips result before use
// - Live outputs readable directly, unlatched
// - Both edges of each output are events
// - Edge requests interrupt only when allowed
// - A/B config bit layout A high nibble
// - C/D config same layout, resets zero
// - Toggle while enabled sets sticky flag
// - Disabled channel reports zero output
// - Status: flags high nibble, live low
// - Threshold registers drive DACs, 00 lowest
`timescale 1ns/1ns
`default_nettype none
`include "acmp_ctrl_consts.svh"

module acmp_ctrl
	import acmp_ctrl_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int SETTLE_CYCLES = `ACMP_SETTLE_CYC
) (
	input wire logic i_ref_clk, // System clock, 250 MHz
	input wire logic i_rstn, // Asynchronous reset, active low
	input wire logic [15:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Register write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	input wire logic [3:0] i_comp_raw, // Asynchronous comparator results, D..A
	output logic [3:0] o_comp_on, // Comparator enables to analog, D..A
	output logic [7:0] o_threshold_code_first, // First threshold DAC code
	output logic [7:0] o_threshold_code_second, // Second threshold DAC code
	output logic [7:0] o_thr_src, // Threshold source per channel, 2 bits each
	output logic o_irq // Level interrupt request
);

	// ************************************************************
	// Checks
	// ************************************************************
	// The register layout fixes the channel count, so anything else is refused at elaboration
	if (CHANNELS != 4) begin : g_chk_channels
		$error("acmp_ctrl serves exactly four channels");
	end
	if (SETTLE_CYCLES < 1) begin : g_chk_settle
		$error("acmp_ctrl settle count must be positive");
	end

	// ************************************************************
	// Registers
	// ************************************************************
	reg_req_t req;
	logic [7:0] ab_config_ff;
	logic [7:0] cd_config_ff;
	logic [7:0] thr_first_ff;
	logic [7:0] thr_second_ff;
	logic [3:0] flag_ff;
	logic [3:0] mask_ff;
	logic [7:0] rdata_ff;
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [3:0] live_prev_ff;
	logic [3:0] settled_ff;
	logic [3:0] nxt_flag;
	logic [3:0] live;
	logic [3:0] edge_evt;
	logic [7:0] status;
	chan_cfg_t cfg [4];

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// Channel order: index 0 = A ... 3 = D
	assign cfg[0] = chan_cfg_t'(ab_config_ff[7:4]);
	assign cfg[1] = chan_cfg_t'(ab_config_ff[3:0]);
	assign cfg[2] = chan_cfg_t'(cd_config_ff[7:4]);
	assign cfg[3] = chan_cfg_t'(cd_config_ff[3:0]);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ab_config_ff <= `ACMP_CFG_RESET;
			cd_config_ff <= `ACMP_CFG_RESET;
		end else if (req.wr) begin
			if (hit(req.addr, `ACMP_OFS_AB_CONFIG)) begin
				ab_config_ff <= req.wdata;
			end
			if (hit(req.addr, `ACMP_OFS_CD_CONFIG)) begin
				cd_config_ff <= req.wdata;
			end
		end
	end

	// Full 8-bit codes: 00 is the lowest threshold, FF the highest
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			thr_first_ff <= `ACMP_THR_RESET;
			thr_second_ff <= `ACMP_THR_RESET;
		end else if (req.wr) begin
			if (hit(req.addr, `ACMP_OFS_THR_FIRST)) begin
				thr_first_ff <= req.wdata;
			end
			if (hit(req.addr, `ACMP_OFS_THR_SECOND)) begin
				thr_second_ff <= req.wdata;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mask_ff <= `ACMP_MASK_RESET;
		end else if (req.wr && hit(req.addr, `ACMP_OFS_IRQ_MASK)) begin
			mask_ff <= req.wdata[3:0];
		end
	end

	// ************************************************************
	// Analog-facing controls
	// ************************************************************
	always_comb begin
		o_thr_src = 8'h00;
		for (int i = 0; i < 4; i++) begin
			o_comp_on[i] = cfg[i].on;
			if (!cfg[i].threshold_choice) begin
				o_thr_src[2*i +: 2] = THR_FIRST;
			end else if (i == 0) begin
				o_thr_src[2*i +: 2] = THR_SECOND;
			end else begin
				o_thr_src[2*i +: 2] = THR_EXTERNAL;
			end
		end
	end

	assign o_threshold_code_first = thr_first_ff;
	assign o_threshold_code_second = thr_second_ff;

	// ************************************************************
	// Synchronise, invert, gate and detect edges
	// ************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= i_comp_raw;
			sync2_ff <= sync1_ff;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Disabled channel is forced low regardless of its invert bit
			live[i] = cfg[i].on & (sync2_ff[i] ^ cfg[i].invert);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			live_prev_ff <= 4'h0;
		end else begin
			live_prev_ff <= live;
		end
	end

	// Enabling a channel can itself make an edge; software should ignore flags
	// raised during the settling window and clear them afterwards
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			edge_evt[i] = cfg[i].on & (live[i] ^ live_prev_ff[i]);
		end
	end

	// Settling tracker: a read-only aid showing channels past their settle time
	logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt_ff [4];
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			settled_ff <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				settle_cnt_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!cfg[i].on) begin
					settle_cnt_ff[i] <= '0;
					settled_ff[i] <= 1'b0;
				end else if (settle_cnt_ff[i] == ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES)) begin
					settled_ff[i] <= 1'b1;
				end else begin
					settle_cnt_ff[i] <= settle_cnt_ff[i] + 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Flags and interrupt
	// ************************************************************
	always_comb begin
		nxt_flag = flag_ff;
		if (req.wr && hit(req.addr, `ACMP_OFS_STATUS)) begin
			nxt_flag = flag_ff & ~req.wdata[7:4];
		end
		// Set wins over a clear in the same cycle
		nxt_flag = nxt_flag | edge_evt;
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_ff <= 4'h0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	always_comb begin
		o_irq = 1'b0;
		for (int i = 0; i < 4; i++) begin
			o_irq = o_irq | (flag_ff[i] & cfg[i].irq_allow & mask_ff[i]);
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	assign status = {flag_ff, live};

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_ff <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`ACMP_OFS_AB_CONFIG: rdata_ff <= ab_config_ff;
				`ACMP_OFS_CD_CONFIG: rdata_ff <= cd_config_ff;
				`ACMP_OFS_THR_FIRST: rdata_ff <= thr_first_ff;
				`ACMP_OFS_THR_SECOND: rdata_ff <= thr_second_ff;
				`ACMP_OFS_STATUS: rdata_ff <= status;
				`ACMP_OFS_IRQ_MASK: rdata_ff <= {4'h0, mask_ff};
				`ACMP_OFS_SETTLED: rdata_ff <= {4'h0, settled_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign o_rdata = rdata_ff;

endmodule
`default_nettype wire

// [core/acmp_ctrl_consts.svh]
// Register offsets, field positions, reset values and timing counts of the comparator control
`ifndef ACMP_CTRL_CONSTS_SVH
`define ACMP_CTRL_CONSTS_SVH

`define ACMP_OFS_AB_CONFIG 16'hA030
`define ACMP_OFS_CD_CONFIG 16'hA031
`define ACMP_OFS_THR_FIRST 16'hA032
`define ACMP_OFS_THR_SECOND 16'hA033
`define ACMP_OFS_STATUS 16'h0094
`define ACMP_OFS_IRQ_MASK 16'hA034
`define ACMP_OFS_SETTLED 16'hA035

`define ACMP_CFG_RESET 8'h00
`define ACMP_THR_RESET 8'h00
`define ACMP_MASK_RESET 4'h0

// Nibble fields inside a configuration register
`define ACMP_FLD_ON 3
`define ACMP_FLD_CHOICE 2
`define ACMP_FLD_IRQ 1
`define ACMP_FLD_INVERT 0

// Status layout
`define ACMP_ST_FLAG_LSB 4
`define ACMP_ST_LIVE_LSB 0

`define ACMP_CLK_MHZ 250
`define ACMP_SETTLE_US 20
`define ACMP_SETTLE_CYC (`ACMP_SETTLE_US * `ACMP_CLK_MHZ)

`endif

// [core/acmp_ctrl_pkg.sv]
// Types shared by the comparator control block
package acmp_ctrl_pkg;

	typedef struct packed {
		logic on;
		logic threshold_choice;
		logic irq_allow;
		logic invert;
	} chan_cfg_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [1:0] {
		THR_FIRST,
		THR_SECOND,
		THR_EXTERNAL
	} thr_src_t;

endpackage

// [verification/acmp_ctrl_checker.sv]
// Port checks of the comparator control
`timescale 1ns/1ns
`default_nettype none
module acmp_ctrl_checker (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [3:0] o_comp_on,
	input wire logic [7:0] o_threshold_code_first,
	input wire logic [7:0] o_thr_src
);
	// ********************************
	// Config writes and their outputs
	// ********************************
	wire logic wab = i_wr && i_addr == 16'hA030;
	wire logic wcd = i_wr && i_addr == 16'hA031;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	a_read_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read");
	a_ab_on: assert property (wab |=>
		o_comp_on[1:0] == {$past(i_wdata[3]), $past(i_wdata[7])}) else $error("A/B enable");
	a_cd_on: assert property (wcd |=>
		o_comp_on[3:2] == {$past(i_wdata[3]), $past(i_wdata[7])}) else $error("C/D enable");
	a_ab_src: assert property (wab |=>
		o_thr_src[3:0] == {$past(i_wdata[2]), 2'b00, $past(i_wdata[6])}) else $error("A/B source");
	a_cd_src: assert property (wcd |=>
		o_thr_src[7:4] == {$past(i_wdata[2]), 1'b0, $past(i_wdata[6]), 1'b0}) else $error("C/D source");
	a_code_write: assert property (i_wr && i_addr == 16'hA032 |=>
		o_threshold_code_first == $past(i_wdata)) else $error("threshold code");
	a_cfg_hold: assert property (!(wab || wcd) |=>
		$stable({o_comp_on, o_thr_src})) else $error("config moved without write");
	sequence s_status_read;
		i_rd && i_addr == 16'h0094;
	endsequence
	a_live_off: assert property (s_status_read |=>
		(o_rdata[3:0] & ~$past(o_comp_on)) == 4'h0) else $error("disabled output not low");
endmodule
`default_nettype wire

// [verification/acmp_cores_model.sv]
// Behavioural comparator cores and threshold DACs
`timescale 1ns/1ns
`default_nettype none
module acmp_cores_model (
	input wire logic i_ref_clk,
	input wire logic [3:0] i_on,
	input wire logic [7:0] i_first,
	input wire logic [7:0] i_second,
	input wire logic [7:0] i_src,
	input wire logic [31:0] i_level,
	input wire logic [7:0] i_ext,
	output logic [3:0] o_raw
);
	// ***************************
	// Threshold pick and compare
	// ***************************
	logic tog_ff = 1'b0;
	logic [7:0] thr;
	// A core that is off gives no steady level, so its output keeps moving
	always @(posedge i_ref_clk) begin
		tog_ff <= ~tog_ff;
	end
	// The shared pin is taken as connected and driven by nothing else
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			thr = i_src[2*i+1] ? i_ext : i_src[2*i] ? i_second : i_first;
			o_raw[i] = i_on[i] ? i_level[8*i +: 8] > thr : tog_ff;
		end
	end
endmodule
`default_nettype wire

// [verification/acmp_ctrl_tb.sv]
// Register-level test of the comparator control
`timescale 1ns/1ns
`default_nettype none
module acmp_ctrl_tb;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] lvl = 32'h10903030;
	logic [3:0] raw, on;
	logic [7:0] rdata, code1, code2, src;
	logic irq;
	logic [15:0] rst_map [8] = '{16'hA030, 16'hA031, 16'hA032, 16'hA033, 16'hA034, 16'hA035,
		16'h0094, 16'h1234};
	int fail_count = 0;
	int samples_checked = 0;
	always #2 i_ref_clk = ~i_ref_clk;
	acmp_ctrl #(.SETTLE_CYCLES(8)) i_acmp_ctrl (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata(rdata), .i_comp_raw(raw), .o_comp_on(on), .o_threshold_code_first(code1),
		.o_threshold_code_second(code2), .o_thr_src(src), .o_irq(irq));
	acmp_cores_model i_acmp_cores_model (.i_ref_clk, .i_on(on), .i_first(code1),
		.i_second(code2), .i_src(src), .i_level(lvl), .i_ext(8'h20), .o_raw(raw));
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("FAIL at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
		if (!w) begin
			chk(rdata, d);
		end
	endtask
	task automatic step(input logic [31:0] v, input logic [7:0] want);
		@(posedge i_ref_clk);
		lvl <= v;
		repeat (5) @(posedge i_ref_clk);
		acc(1'b0, 16'h0094, want);
	endtask
	task automatic finish_test();
		$display("compares %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		finish_test();
	end
	// **************
	// Test sequence
	// **************
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		foreach (rst_map[k]) begin
			acc(1'b0, rst_map[k], 8'h00);
		end
		acc(1'b1, 16'hA032, 8'h80);
		acc(1'b1, 16'hA033, 8'h40);
		acc(1'b0, 16'hA033, 8'h40);
		chk(code1, 8'h80);
		chk(code2, 8'h40);
		acc(1'b1, 16'hA030, 8'hEF);
		acc(1'b1, 16'hA031, 8'h8E);
		acc(1'b0, 16'hA030, 8'hEF);
		chk(src, 8'h89);
		chk({4'h0, on}, 8'h0F);
		// Edges seen while the cores settle are not real events
		repeat (10) @(posedge i_ref_clk);
		acc(1'b1, 16'h0094, 8'hF0);
		acc(1'b0, 16'h0094, 8'h04);
		acc(1'b0, 16'hA035, 8'h0F);
		acc(1'b1, 16'hA034, 8'h0F);
		step(32'h10703030, 8'h40);
		chk({7'h00, irq}, 8'h00);
		acc(1'b1, 16'h0094, 8'hF0);
		step(32'h30701050, 8'hBB);
		chk({7'h00, irq}, 8'h01);
		acc(1'b1, 16'h0094, 8'hF0);
		step(32'h30701030, 8'h1A);
		acc(1'b1, 16'hA034, 8'h0E);
		chk({7'h00, irq}, 8'h00);
		acc(1'b1, 16'hA030, 8'h00);
		repeat (5) @(posedge i_ref_clk);
		acc(1'b0, 16'hA035, 8'h0C);
		acc(1'b1, 16'h0094, 8'hF0);
		step(32'h30701030, 8'h08);
		@(posedge i_ref_clk);
		i_rstn <= 1'b0;
		@(posedge i_ref_clk);
		i_rstn <= 1'b1;
		acc(1'b0, 16'hA031, 8'h00);
		finish_test();
	end
endmodule
bind acmp_ctrl acmp_ctrl_checker i_acmp_ctrl_checker (.i_ref_clk, .i_rstn, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .o_comp_on, .o_threshold_code_first, .o_thr_src);
`default_nettype wire
